// ===== arf_defines.svh
// offsets, field positions, reset values and timing counts of the result formatter
`ifndef ARF_DEFINES_SVH
`define ARF_DEFINES_SVH

// register byte addresses
`define ARF_OFF_CTRL0       12'h000
`define ARF_OFF_CTRL1       12'h004
`define ARF_OFF_RES_HIGH    12'h008
`define ARF_OFF_RES_LOW     12'h00C
`define ARF_OFF_RAW_RESULT  12'h010

// control 0 fields
`define ARF_C0_ENABLE_BIT   0
`define ARF_C0_START_BIT    1
`define ARF_C0_CHAN_LSB     2
`define ARF_C0_CHAN_MSB     6
`define ARF_C0_IMPL_MASK    8'h7F

// control 1 fields
`define ARF_C1_FORMAT_BIT   7
`define ARF_C1_IMPL_MASK    8'hF7

// reset values
`define ARF_C0_RESET        8'h00
`define ARF_C1_RESET        8'h00
`define ARF_RES_RESET       8'h00

// conversion length in cycles of pclk
`define ARF_CONV_CYCLES     6'd22

`endif

// ===== arf_justify.sv
// splits a 10-bit result into high and low result bytes
`timescale 1ns/10ps

module arf_justify (
    input  wire logic [9:0] conversion_result,    // raw 10-bit result
    input  wire logic       result_format_select, // 1 right, 0 left
    output logic      [7:0] high_byte,            // formatted high byte
    output logic      [7:0] low_byte              // formatted low byte
);

    // pure combinational packing
    always_comb begin
        if (result_format_select) begin
            high_byte = {6'b00_0000, conversion_result[9:8]};
            low_byte  = conversion_result[7:0];
        end else begin
            high_byte = conversion_result[9:2];
            low_byte  = {conversion_result[1:0], 6'b00_0000};
        end
    end

endmodule

// ===== arf_pkg.sv
// types shared by the result formatter files
package arf_pkg;

    typedef enum logic [1:0] {
        ARF_IDLE,
        ARF_CONVERT,
        ARF_LOAD
    } arf_state_e;

    typedef logic [9:0] arf_result_t;

endpackage

// ===== arf_top.sv
// result formatter of a 10-bit converter with an apb register slave
// Functional notes
// - left mode: low two bits at low 7-6
// - right mode: top two bits at high 1-0
// - right mode: low eight bits fill low byte
// - left mode: top eight bits fill high
// - unused result positions loaded as zero
// - unimplemented control bits read zero, ignore writes
`timescale 1ns/10ps
`include "arf_defines.svh"

module arf_top (
    input  wire logic        pclk,             // system clock
    input  wire logic        presetn,          // async reset, active low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb access phase
    input  wire logic        pwrite,           // apb direction
    input  wire logic [11:0] paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    input  wire logic [9:0]  sample_value,     // converter core value, same clock
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    output logic             conversion_done,  // one-cycle completion pulse
    output logic             converter_enable, // enable bit to the analog side
    output logic      [4:0]  input_channel_select // selected analog channel
);

    ////////////////////////////////////////////////////////////////////////
    // state

    // one packed image holds every register of the block, so the next
    // state starts from a full copy and changes only the fields it needs
    typedef struct packed {
        arf_pkg::arf_state_e state;     // conversion sequencer
        logic [5:0]          count;     // conversion cycle counter
        logic [7:0]          ctrl0;     // control 0 image
        logic [7:0]          ctrl1;     // control 1 image
        logic [7:0]          res_high;  // result high byte
        logic [7:0]          res_low;   // result low byte
        arf_pkg::arf_result_t raw;      // last raw result
        logic [31:0]         rdata;     // read data register
        logic                ready;     // ready register
        logic                err;       // error register
        logic                done;      // completion pulse
    } arf_state_s;

    arf_state_s s_q;          // registered state
    arf_state_s s_d;          // next state
    logic [7:0] fmt_high;     // formatted high byte
    logic [7:0] fmt_low;      // formatted low byte
    logic       setup;        // apb setup phase seen
    logic       wr_acc;       // write takes effect this edge
    logic       fmt_sel;      // current format select

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // the raw result offset is mapped as well, read only; any other
    // offset answers with an error and is never written
    // true when address hits a mapped register
    function automatic logic arf_mapped(input logic [11:0] a);
        arf_mapped = (a == `ARF_OFF_CTRL0) || (a == `ARF_OFF_CTRL1) ||
                     (a == `ARF_OFF_RES_HIGH) || (a == `ARF_OFF_RES_LOW) ||
                     (a == `ARF_OFF_RAW_RESULT);
    endfunction

    // format select as it stands now; the load cycle uses this value
    assign fmt_sel = s_q.ctrl1[`ARF_C1_FORMAT_BIT];
    // a fresh request only while no answer is pending
    assign setup   = psel && !penable && !s_q.ready;
    // a write lands only on the access edge of a mapped register
    assign wr_acc  = psel && penable && s_q.ready && pwrite && !s_q.err;

    // result packing from the raw value
    // combinational, so the format in force at load time decides
    arf_justify u_justify (
        .conversion_result    (s_q.raw),
        .result_format_select (fmt_sel),
        .high_byte            (fmt_high),
        .low_byte             (fmt_low)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    // the bus answers every request after exactly one wait-free setup
    // cycle; read data is captured at setup and stands for the one access
    // cycle in which pready is high
    //
    // the sequencer walks idle, convert and load; the raw value is taken
    // in the last convert cycle and both result bytes are written from it
    // in the single load cycle, together with the completion pulse, so a
    // reader after the pulse never sees a mix of two results
    always_comb begin
        // hold every field; pulses drop unless raised below
        s_d       = s_q;
        s_d.done  = 1'b0;
        s_d.ready = 1'b0;
        s_d.err   = 1'b0;

        // apb: answer one cycle after setup
        if (setup) begin
            s_d.ready = 1'b1;
            // pslverr rides with pready for an unmapped offset
            s_d.err   = !arf_mapped(paddr);
            // writes and unmapped reads return zero read data
            s_d.rdata = 32'h0000_0000;
            // read data picked by address; control bytes are masked
            if (!pwrite) begin
                if (paddr == `ARF_OFF_CTRL0) begin
                    s_d.rdata = {24'h00_0000, s_q.ctrl0 & `ARF_C0_IMPL_MASK};
                end else if (paddr == `ARF_OFF_CTRL1) begin
                    s_d.rdata = {24'h00_0000, s_q.ctrl1 & `ARF_C1_IMPL_MASK};
                end else if (paddr == `ARF_OFF_RES_HIGH) begin
                    s_d.rdata = {24'h00_0000, s_q.res_high};
                end else if (paddr == `ARF_OFF_RES_LOW) begin
                    s_d.rdata = {24'h00_0000, s_q.res_low};
                end else if (paddr == `ARF_OFF_RAW_RESULT) begin
                    // all ten raw bits, zero above
                    s_d.rdata = {22'h00_0000, s_q.raw};
                end
            end
        end

        // register writes; result bytes are writable, but a load in
        // the same cycle overrides the software value
        if (wr_acc) begin
            if (paddr == `ARF_OFF_CTRL0) begin
                // implemented bits only, padding stays zero; the
                // start bit is kept by hardware while converting
                s_d.ctrl0 = pwdata[7:0] & `ARF_C0_IMPL_MASK;
                if (s_q.state != arf_pkg::ARF_IDLE) begin
                    s_d.ctrl0[`ARF_C0_START_BIT] = 1'b1;
                end
            end else if (paddr == `ARF_OFF_CTRL1) begin
                // bit 3 is padding and never sets
                s_d.ctrl1 = pwdata[7:0] & `ARF_C1_IMPL_MASK;
            end else if (paddr == `ARF_OFF_RES_HIGH) begin
                s_d.res_high = pwdata[7:0];
            end else if (paddr == `ARF_OFF_RES_LOW) begin
                s_d.res_low = pwdata[7:0];
            end
        end

        // conversion sequencer; acquisition wait is software's duty
        // it reads the updated control image, so a start write counts at once
        case (s_q.state)
            arf_pkg::ARF_IDLE: begin
                // start needs enable; a lone start bit is dropped
                if (s_d.ctrl0[`ARF_C0_START_BIT] && s_d.ctrl0[`ARF_C0_ENABLE_BIT]) begin
                    s_d.state = arf_pkg::ARF_CONVERT;
                    s_d.count = `ARF_CONV_CYCLES;
                end else begin
                    s_d.ctrl0[`ARF_C0_START_BIT] = 1'b0;
                end
            end
            arf_pkg::ARF_CONVERT: begin
                if (!s_d.ctrl0[`ARF_C0_ENABLE_BIT]) begin
                    // disable aborts without a result
                    s_d.state = arf_pkg::ARF_IDLE;
                    s_d.ctrl0[`ARF_C0_START_BIT] = 1'b0;
                end else if (s_q.count == 6'd1) begin
                    // last convert cycle: take the core value
                    s_d.raw   = sample_value;
                    s_d.state = arf_pkg::ARF_LOAD;
                end else begin
                    // count down the conversion length
                    s_d.count = s_q.count - 6'd1;
                end
            end
            arf_pkg::ARF_LOAD: begin
                // both bytes and done together, current format
                s_d.res_high = fmt_high;
                s_d.res_low  = fmt_low;
                // a start write in this cycle is lost to the clear
                s_d.ctrl0[`ARF_C0_START_BIT] = 1'b0;
                s_d.done  = 1'b1;
                s_d.state = arf_pkg::ARF_IDLE;
            end
            default: begin
                // unused encoding falls back to idle
                s_d.state = arf_pkg::ARF_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // asynchronous clear to the reset image; every field is listed so
    // that no bit of the image comes out of reset unknown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.state    <= arf_pkg::ARF_IDLE;
            s_q.count    <= 6'd0;
            s_q.ctrl0    <= `ARF_C0_RESET;
            s_q.ctrl1    <= `ARF_C1_RESET;
            s_q.res_high <= `ARF_RES_RESET;
            s_q.res_low  <= `ARF_RES_RESET;
            s_q.raw      <= 10'h000;
            s_q.rdata    <= 32'h0000_0000;
            s_q.ready    <= 1'b0;
            s_q.err      <= 1'b0;
            s_q.done     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops

    // every output is a field of the registered image, no logic after it
    assign prdata               = s_q.rdata;
    assign pready               = s_q.ready;
    assign pslverr              = s_q.err;
    assign conversion_done      = s_q.done;
    // enable and channel select go straight to the analog side
    assign converter_enable     = s_q.ctrl0[`ARF_C0_ENABLE_BIT];
    assign input_channel_select = s_q.ctrl0[`ARF_C0_CHAN_MSB:`ARF_C0_CHAN_LSB];

endmodule

// ===== arf_top_props.sv
// port assertions for the result formatter
`timescale 1ns/10ps
module arf_top_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        conversion_done,
    input wire logic        converter_enable,
    input wire logic [4:0]  input_channel_select
);
    logic acc;   // completed transfer
    logic fmt_q; // last written format
    logic sw_q;  // result bytes stale
    assign acc = psel && penable && pready;
    ////////////////////////////////////////////////////////////////
    // track format and software writes that spoil the zero fill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q <= 1'b0;
            sw_q  <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == 12'h004)
                fmt_q <= pwdata[7];
            // a software write after the load spoils the bytes again
            if (acc && pwrite && paddr inside {12'h004, 12'h008, 12'h00C})
                sw_q <= 1'b1;
            else if (conversion_done)
                sw_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ctrl0_pad_a : assert property (
        acc && !pwrite && paddr == 12'h000 |-> prdata[7] == 1'b0)
        else $error("control 0 bit 7 reads one");
    ctrl1_pad_a : assert property (
        acc && !pwrite && paddr == 12'h004 |-> prdata[3] == 1'b0)
        else $error("control 1 bit 3 reads one");
    ctrl_write_a : assert property (
        acc && pwrite && paddr == 12'h000 |=> converter_enable == $past(pwdata[0])
        && input_channel_select == $past(pwdata[6:2]))
        else $error("control 0 write not applied");
    done_pulse_a : assert property (
        conversion_done |=> !conversion_done)
        else $error("completion pulse too long");
    high_right_a : assert property (
        acc && !pwrite && paddr == 12'h008 && fmt_q && !sw_q |-> prdata[7:2] == 6'h00)
        else $error("high byte upper bits not zero");
    low_left_a : assert property (
        acc && !pwrite && paddr == 12'h00C && !fmt_q && !sw_q |-> prdata[5:0] == 6'h00)
        else $error("low byte lower bits not zero");
    byte_pad_a : assert property (
        acc && !pwrite && paddr inside {12'h008, 12'h00C} |-> prdata[31:8] == 24'h00_0000)
        else $error("result read upper bits not zero");
    cover property (conversion_done);
    cover property (acc && !pwrite && paddr == 12'h008 && fmt_q && !sw_q);
    cover property (acc && !pwrite && paddr == 12'h00C && !fmt_q && !sw_q);
endmodule
bind arf_top arf_top_props i_arf_top_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .conversion_done(conversion_done), .converter_enable(converter_enable),
    .input_channel_select(input_channel_select));

// ===== test_adc_result_formatter.sv
// self-checking bench for the result formatter
`timescale 1ns/10ps
`include "arf_defines.svh"
module test_adc_result_formatter;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  sample_value;
    logic        conversion_done, converter_enable;
    logic [4:0]  input_channel_select;
    int          n_errors, tests_run;
    arf_top i_arf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sample_value(sample_value),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conversion_done(conversion_done),
        .converter_enable(converter_enable), .input_channel_select(input_channel_select));
    ////////////////////////////////////////////////////////////////
    // verdict, compare and bus cycle
    task print_verdict;
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    // reset values, padding bits, unmapped access
    task t_regs;
        apb(1'b0, `ARF_OFF_CTRL0, 32'h0);
        chk(rd, {24'h00_0000, `ARF_C0_RESET});
        apb(1'b0, `ARF_OFF_CTRL1, 32'h0);
        chk(rd, {24'h00_0000, `ARF_C1_RESET});
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0000_00FC);
        apb(1'b0, `ARF_OFF_CTRL0, 32'h0);
        chk(rd, 32'h0000_007C);
        chk({27'h000_0000, input_channel_select}, 32'h0000_001F);
        apb(1'b1, `ARF_OFF_CTRL1, 32'h0000_00FF);
        apb(1'b0, `ARF_OFF_CTRL1, 32'h0);
        chk(rd, 32'h0000_00F7);
        apb(1'b1, 12'h014, 32'h0000_00AA);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0);
    endtask
    // one conversion in the given format over dirtied result bytes
    task t_conv(input logic f, input logic [9:0] v);
        int n;
        apb(1'b1, `ARF_OFF_CTRL1, {24'h00_0000, f, 7'h00});
        apb(1'b1, `ARF_OFF_RES_HIGH, 32'h0000_00FF);
        apb(1'b1, `ARF_OFF_RES_LOW, 32'h0000_00FF);
        sample_value <= v;
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0000_0015);
        repeat (8) @(posedge pclk);
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0000_0017);
        for (n = 0; n < 60 && conversion_done !== 1'b1; n++) @(posedge pclk);
        chk({31'h0, n < 60}, 32'h0000_0001);
        chk(n, `ARF_CONV_CYCLES + 32'd2);
        apb(1'b0, `ARF_OFF_RES_HIGH, 32'h0);
        chk(rd, f ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
        apb(1'b0, `ARF_OFF_RES_LOW, 32'h0);
        chk(rd, f ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
        apb(1'b0, `ARF_OFF_RAW_RESULT, 32'h0);
        chk(rd, {22'h0, v});
        apb(1'b0, `ARF_OFF_CTRL0, 32'h0);
        chk(rd, 32'h0000_0015);
        chk({26'h0, input_channel_select, converter_enable}, 32'h0000_000B);
    endtask
    // disable in mid-conversion aborts with no result; raw result is unchanged
    task t_abort(input logic [9:0] v, input logic [9:0] prev);
        int k;
        int hits;
        hits = 0;
        sample_value <= v;
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0000_0017);
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0000_0015);
        apb(1'b0, `ARF_OFF_CTRL0, 32'h0);
        chk(rd, 32'h0000_0017);
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0000_0014);
        for (k = 0; k < 30; k++) begin
            @(posedge pclk);
            if (conversion_done !== 1'b0) hits++;
        end
        chk(hits, 32'h0000_0000);
        apb(1'b0, `ARF_OFF_RAW_RESULT, 32'h0);
        chk(rd, {22'h0, prev});
        chk({31'h0, converter_enable}, 32'h0000_0000);
    endtask
    // reset in mid-conversion returns the control and result byte registers to their reset values
    task t_reset;
        int k;
        int hits;
        hits = 0;
        apb(1'b1, `ARF_OFF_CTRL0, 32'h0000_0017);
        repeat (4) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 30; k++) begin
            @(posedge pclk);
            if (conversion_done !== 1'b0) hits++;
        end
        chk(hits, 32'h0000_0000);
        chk({26'h0, input_channel_select, converter_enable}, 32'h0000_0000);
        apb(1'b0, `ARF_OFF_CTRL0, 32'h0);
        chk(rd, {24'h00_0000, `ARF_C0_RESET});
        apb(1'b0, `ARF_OFF_CTRL1, 32'h0);
        chk(rd, {24'h00_0000, `ARF_C1_RESET});
        apb(1'b0, `ARF_OFF_RES_HIGH, 32'h0);
        chk(rd, {24'h00_0000, `ARF_RES_RESET});
        apb(1'b0, `ARF_OFF_RES_LOW, 32'h0);
        chk(rd, {24'h00_0000, `ARF_RES_RESET});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // watchdog for a hung handshake
    initial begin
        #50000;
        n_errors++;
        print_verdict;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sample_value} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_conv(1'b1, 10'h3FF);
        t_conv(1'b0, 10'h3FF);
        t_conv(1'b1, 10'h2A5);
        t_conv(1'b0, 10'h15A);
        t_abort(10'h0C3, 10'h15A);
        t_reset;
        print_verdict;
    end
endmodule
